// ---- hw/dioec_pkg.sv ----
package dioec_pkg;

   // ----------------------------------------------------------------
   // channel layout
   // ----------------------------------------------------------------
   localparam int unsigned DIOEC_NUM_CH    = 72;
   localparam int unsigned DIOEC_NUM_EDGE  = 64;
   localparam int unsigned DIOEC_NUM_LATCH = 8;
   localparam int unsigned DIOEC_DIR_W     = 10;
   localparam int unsigned DIOEC_GRP_LO    = 8;   // channels per low group
   localparam int unsigned DIOEC_GRP_HI    = 4;   // channels per high group
   localparam int unsigned DIOEC_SUM_W     = 16;  // channels per summary bit
   localparam int unsigned DIOEC_ADDR_W    = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] DIOEC_OFS_PORT0 = 8'h00;
   localparam logic [7:0] DIOEC_OFS_PORT1 = 8'h04;
   localparam logic [7:0] DIOEC_OFS_PORT2 = 8'h08;
   localparam logic [7:0] DIOEC_OFS_RO0C  = 8'h0c;
   localparam logic [7:0] DIOEC_OFS_RO10  = 8'h10;
   localparam logic [7:0] DIOEC_OFS_FLAG0 = 8'h14;
   localparam logic [7:0] DIOEC_OFS_FLAG1 = 8'h18;
   localparam logic [7:0] DIOEC_OFS_EDGE0 = 8'h1c;
   localparam logic [7:0] DIOEC_OFS_EDGE1 = 8'h20;
   localparam logic [7:0] DIOEC_OFS_ARM0  = 8'h24;
   localparam logic [7:0] DIOEC_OFS_ARM1  = 8'h28;
   localparam logic [7:0] DIOEC_OFS_IEN0  = 8'h2c;
   localparam logic [7:0] DIOEC_OFS_IEN1  = 8'h30;
   localparam logic [7:0] DIOEC_OFS_CTRL  = 8'h34;

   // ----------------------------------------------------------------
   // control register field positions
   // ----------------------------------------------------------------
   localparam int unsigned DIOEC_BIT_ARM     = 15;
   localparam int unsigned DIOEC_BIT_GIE     = 16;
   localparam int unsigned DIOEC_BIT_LOE     = 17;
   localparam int unsigned DIOEC_CAP_LSB     = 21;
   localparam int unsigned DIOEC_REQ_LSB     = 25;
   localparam int unsigned DIOEC_BIT_GREQ    = 31;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [9:0]  DIOEC_RST_DIR  = 10'h000;
   localparam logic        DIOEC_RST_GIE  = 1'b0;
   localparam logic        DIOEC_RST_LOE  = 1'b0;
   localparam logic [63:0] DIOEC_RST_IEN  = 64'h0000_0000_0000_0000;
   localparam logic [63:0] DIOEC_RST_ARM  = 64'h0000_0000_0000_0000;
   localparam logic [63:0] DIOEC_RST_EDGE = 64'h0000_0000_0000_0000;
   localparam logic [71:0] DIOEC_RST_OUT  = 72'h00_0000_0000_0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dioec_req_type;

   typedef struct packed {
      logic        rvalid;
      logic [31:0] rdata;
   } dioec_rsp_type;

   typedef struct packed {
      logic [71:0] outreg;    // output registers
      logic [9:0]  dir;       // direction group bits
      logic        arm_set;   // arm write polarity
      logic        global_irq_enable;       // global_irq_enable
      logic        latch_output_mode;       // latch_output_mode
      logic [63:0] edge_sel;  // 0 rising, 1 falling
      logic [63:0] arm;       // capture arming
      logic [63:0] cap;       // capture flags
      logic [63:0] ien;       // per-channel irq enables
      logic [63:0] prev_pin;  // previous synced level
      logic [7:0]  hold;      // latched channels 64-71
      logic        prev_latch;
      dioec_rsp_type rsp;
   } dioec_state_type;

endpackage

// ---- hw/dioec_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module dioec_sync
   import dioec_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } dioec_sync_type;

   dioec_sync_type s_r;
   dioec_sync_type s_nxt;

   // ----------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------
   // first stage feeds only the second
   always_comb begin
      s_nxt.meta = d_i;
      s_nxt.sync = s_r.meta;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.sync;

   // a zero-width synchroniser has nothing to carry
   if (WIDTH == 0) begin : g_width_check
      $error("dioec_sync: WIDTH must be nonzero");
   end

endmodule

`default_nettype wire

// ---- hw/dioec_top.sv ----
// Overview of operation
// - reset clears global_irq_enable, no interrupt request leaves the block.
// - reset clears every per-channel interrupt enable bit.
// - reset clears all direction bits, all 72 channels become inputs.
// - reset clears latch_output_mode, channels 64-71 act as plain I/O.
// - status_led is lit while latch_output_mode is clear.
// - channels 0-63 form eight groups of eight, one direction bit each.
// - channels 64-71 form two groups of four, one direction bit each.
// - direction bits 9..0 at offset 0x34, bit 0 is channels 0-7.
// - direction bit zero means inputs, one means driven outputs.
// - a group turned output drives its already held output register.
// - port read returns pin level for inputs (held value for 64-71 in latch mode), output register else.
// - port data pass uninverted in both directions.
// - channels 0-31 at 0x00, 32-63 at 0x04, 64-71 at 0x08.
// - latch mode applies to all eight channels 64-71 together.
// - latch strobe captures inputs 64-71, held for later host reads.
// - in latch mode outputs 64-71 float unless output gate is asserted.
// - captured edge requests interrupt only if enabled, and sets its flag.
// - each input channel 0-63 selects rising or falling edge capture.
// - summary status bits of the control register ignore host writes.
// - capture arming at 0x24 and 0x28, readable and writable.
// - interrupt flags read-only at 0x14 and 0x18, enables at 0x2c and 0x30.
// - latch strobe capture happens on its high-to-low transition.
// - edge select zero picks rising, one picks falling.
// - latch_output_mode is bit 17 and global_irq_enable bit 16 of 0x34.
// - clear global_irq_enable blocks every interrupt to the host.
`timescale 1ns/1ps
`default_nettype none

module dioec_top
   import dioec_pkg::*;
#(
   parameter int unsigned NUM_CH   = DIOEC_NUM_CH,
   parameter int unsigned NUM_EDGE = DIOEC_NUM_EDGE
) (
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire dioec_req_type reg_req_i,
   output dioec_rsp_type      reg_rsp_o,
   input  wire logic [71:0]   gpio_in_i,
   output logic      [71:0]   gpio_out_o,
   output logic      [71:0]   gpio_oe_o,
   input  wire logic          latch_strobe_i,
   input  wire logic          output_gate_strobe_n_i,
   output logic               status_led_o,
   output logic               irq_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the channel map is fixed, other counts cannot be served
   if (NUM_CH != DIOEC_NUM_CH) begin : g_ch_check
      $error("dioec_top: NUM_CH must be 72");
   end
   if (NUM_EDGE != DIOEC_NUM_EDGE) begin : g_edge_check
      $error("dioec_top: NUM_EDGE must be 64");
   end

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // expand direction bits into a per-channel enable mask
   function automatic logic [71:0] dir_mask(input logic [9:0] dir);
      logic [71:0] m;
      m = '0;
      for (int g = 0; g < 8; g++) begin
         m[g*DIOEC_GRP_LO +: DIOEC_GRP_LO] = {DIOEC_GRP_LO{dir[g]}};
      end
      m[64 +: DIOEC_GRP_HI] = {DIOEC_GRP_HI{dir[8]}};
      m[68 +: DIOEC_GRP_HI] = {DIOEC_GRP_HI{dir[9]}};
      return m;
   endfunction

   // per-bit choice of pin level or output register
   function automatic logic [31:0] port_mix(input logic [31:0] pin,
                                            input logic [31:0] outv,
                                            input logic [31:0] isout);
      return (pin & ~isout) | (outv & isout);
   endfunction

   // reduce 64 channels into four 16-channel summary bits
   function automatic logic [3:0] bank_or(input logic [63:0] v);
      logic [3:0] r;
      r = '0;
      for (int b = 0; b < 4; b++) begin
         r[b] = |v[b*DIOEC_SUM_W +: DIOEC_SUM_W];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [73:0] sync_q;
   logic [71:0] pin_s;
   logic        latch_s;
   logic        gate_n_s;

   dioec_sync #(
      .WIDTH (74)
   ) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    ({output_gate_strobe_n_i, latch_strobe_i, gpio_in_i}),
      .q_o    (sync_q)
   );

   assign pin_s    = sync_q[71:0];
   assign latch_s  = sync_q[72];
   assign gate_n_s = sync_q[73];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dioec_state_type s_r;
   dioec_state_type s_nxt;

   logic [71:0] out_mask;
   logic [63:0] rise;
   logic [63:0] fall;
   logic [63:0] hit;
   logic [63:0] flags;
   logic [3:0]  bank_req;
   logic [3:0]  bank_cap;
   logic        glob_req;
   logic        latch_fall;
   logic [7:0]  hi_in;
   logic [31:0] ctrl_rd;

   // ----------------------------------------------------------------
   // derived signals
   // ----------------------------------------------------------------
   // direction mask and edge detection
   assign out_mask = dir_mask(s_r.dir);
   assign rise     = pin_s[63:0] & ~s_r.prev_pin;
   assign fall     = ~pin_s[63:0] & s_r.prev_pin;
   // pick edge per channel, only armed channels capture
   assign hit = ((rise & ~s_r.edge_sel) | (fall & s_r.edge_sel))
              & s_r.arm;

   // interrupt flags and summaries
   assign flags    = s_r.cap & s_r.ien;
   assign bank_req = bank_or(flags);
   assign bank_cap = bank_or(s_r.cap);
   assign glob_req = s_r.global_irq_enable & (|flags);

   // latch strobe falling edge, all eight channels together
   assign latch_fall = s_r.latch_output_mode & s_r.prev_latch & ~latch_s;

   // input view of channels 64-71
   assign hi_in = s_r.latch_output_mode ? s_r.hold : pin_s[71:64];

   // control register read view, status bits are live
   always_comb begin
      ctrl_rd                     = 32'h0000_0000;
      ctrl_rd[DIOEC_DIR_W-1:0]    = s_r.dir;
      ctrl_rd[DIOEC_BIT_ARM]      = s_r.arm_set;
      ctrl_rd[DIOEC_BIT_GIE]      = s_r.global_irq_enable;
      ctrl_rd[DIOEC_BIT_LOE]      = s_r.latch_output_mode;
      ctrl_rd[DIOEC_CAP_LSB +: 4] = bank_cap;
      ctrl_rd[DIOEC_REQ_LSB +: 4] = bank_req;
      ctrl_rd[DIOEC_BIT_GREQ]     = glob_req;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp.rvalid = 1'b0;
      s_nxt.prev_pin   = pin_s[63:0];
      s_nxt.prev_latch = latch_s;

      // host writes
      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            DIOEC_OFS_PORT0: begin
               s_nxt.outreg[31:0] = reg_req_i.wdata;
            end
            DIOEC_OFS_PORT1: begin
               s_nxt.outreg[63:32] = reg_req_i.wdata;
            end
            DIOEC_OFS_PORT2: begin
               s_nxt.outreg[71:64] = reg_req_i.wdata[7:0];
            end
            DIOEC_OFS_EDGE0: begin
               s_nxt.edge_sel[31:0] = reg_req_i.wdata;
            end
            DIOEC_OFS_EDGE1: begin
               s_nxt.edge_sel[63:32] = reg_req_i.wdata;
            end
            DIOEC_OFS_ARM0: begin
               // ones in the word arm or disarm by the arm polarity bit
               if (s_r.arm_set) begin
                  s_nxt.arm[31:0] = s_r.arm[31:0] | reg_req_i.wdata;
               end else begin
                  s_nxt.arm[31:0] = s_r.arm[31:0] & ~reg_req_i.wdata;
               end
            end
            DIOEC_OFS_ARM1: begin
               if (s_r.arm_set) begin
                  s_nxt.arm[63:32] = s_r.arm[63:32] | reg_req_i.wdata;
               end else begin
                  s_nxt.arm[63:32] = s_r.arm[63:32] & ~reg_req_i.wdata;
               end
            end
            DIOEC_OFS_IEN0: begin
               s_nxt.ien[31:0] = reg_req_i.wdata;
            end
            DIOEC_OFS_IEN1: begin
               s_nxt.ien[63:32] = reg_req_i.wdata;
            end
            DIOEC_OFS_CTRL: begin
               // summary bits are not writable
               s_nxt.dir     = reg_req_i.wdata[DIOEC_DIR_W-1:0];
               s_nxt.arm_set = reg_req_i.wdata[DIOEC_BIT_ARM];
               s_nxt.global_irq_enable     = reg_req_i.wdata[DIOEC_BIT_GIE];
               s_nxt.latch_output_mode     = reg_req_i.wdata[DIOEC_BIT_LOE];
            end
            default: begin
               // read-only or unmapped: write ignored
            end
         endcase
      end

      // capture flags: disarm clears, a new edge wins over the clear
      s_nxt.cap = (s_r.cap & s_nxt.arm) | hit;

      // latch holding register
      if (latch_fall) begin
         s_nxt.hold = pin_s[71:64];
      end

      // host reads, data registered
      if (reg_req_i.rd) begin
         s_nxt.rsp.rvalid = 1'b1;
         case (reg_req_i.addr)
            DIOEC_OFS_PORT0: begin
               s_nxt.rsp.rdata = port_mix(pin_s[31:0], s_r.outreg[31:0],
                                          out_mask[31:0]);
            end
            DIOEC_OFS_PORT1: begin
               s_nxt.rsp.rdata = port_mix(pin_s[63:32], s_r.outreg[63:32],
                                          out_mask[63:32]);
            end
            DIOEC_OFS_PORT2: begin
               s_nxt.rsp.rdata = port_mix({24'h000000, hi_in},
                                          {24'h000000, s_r.outreg[71:64]},
                                          {24'h000000, out_mask[71:64]});
            end
            DIOEC_OFS_FLAG0: begin
               s_nxt.rsp.rdata = flags[31:0];
            end
            DIOEC_OFS_FLAG1: begin
               s_nxt.rsp.rdata = flags[63:32];
            end
            DIOEC_OFS_EDGE0: begin
               s_nxt.rsp.rdata = s_r.edge_sel[31:0];
            end
            DIOEC_OFS_EDGE1: begin
               s_nxt.rsp.rdata = s_r.edge_sel[63:32];
            end
            DIOEC_OFS_ARM0: begin
               s_nxt.rsp.rdata = s_r.arm[31:0];
            end
            DIOEC_OFS_ARM1: begin
               s_nxt.rsp.rdata = s_r.arm[63:32];
            end
            DIOEC_OFS_IEN0: begin
               s_nxt.rsp.rdata = s_r.ien[31:0];
            end
            DIOEC_OFS_IEN1: begin
               s_nxt.rsp.rdata = s_r.ien[63:32];
            end
            DIOEC_OFS_CTRL: begin
               s_nxt.rsp.rdata = ctrl_rd;
            end
            default: begin
               s_nxt.rsp.rdata = 32'h0000_0000; // unmapped and 0x0c, 0x10
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // every control bit gets a defined value after reset
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_r.outreg     <= DIOEC_RST_OUT;
         s_r.dir        <= DIOEC_RST_DIR;
         s_r.arm_set    <= 1'b0;
         s_r.global_irq_enable        <= DIOEC_RST_GIE;
         s_r.latch_output_mode        <= DIOEC_RST_LOE;
         s_r.edge_sel   <= DIOEC_RST_EDGE;
         s_r.arm        <= DIOEC_RST_ARM;
         s_r.cap        <= 64'h0000_0000_0000_0000;
         s_r.ien        <= DIOEC_RST_IEN;
         s_r.prev_pin   <= 64'h0000_0000_0000_0000;
         s_r.hold       <= 8'h00;
         s_r.prev_latch <= 1'b0;
         s_r.rsp        <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // output data straight from the output registers
   assign gpio_out_o = s_r.outreg;

   // drivers follow direction, high channels gated in latch mode
   always_comb begin
      gpio_oe_o = out_mask;
      if (s_r.latch_output_mode && gate_n_s) begin
         gpio_oe_o[71:64] = 8'h00;
      end
   end

   // led lit while latch mode is off
   assign status_led_o = ~s_r.latch_output_mode;

   // host interrupt request
   assign irq_o = glob_req;

   // register bus answer
   assign reg_rsp_o = s_r.rsp;

endmodule

`default_nettype wire

// ---- dv/dioec_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dioec_checker
   import dioec_pkg::*;
#(
   parameter int unsigned NUM_CH   = DIOEC_NUM_CH,
   parameter int unsigned NUM_EDGE = DIOEC_NUM_EDGE
) (
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire dioec_req_type reg_req_i,
   input  wire dioec_rsp_type reg_rsp_o,
   input  wire logic [71:0]   gpio_in_i,
   input  wire logic [71:0]   gpio_out_o,
   input  wire logic [71:0]   gpio_oe_o,
   input  wire logic          latch_strobe_i,
   input  wire logic          output_gate_strobe_n_i,
   input  wire logic          status_led_o,
   input  wire logic          irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic       wr_ctrl;
   logic       rd_only;
   logic [71:0] prev_r;
   logic [1:0]  same_r;
   // expand direction bits to channels
   function automatic logic [71:0] grp(input logic [9:0] d);
      for (int i = 0; i < 72; i++)
         grp[i] = (i < 64) ? d[i/8] : d[8+(i-64)/4];
   endfunction
   assign wr_ctrl = reg_req_i.wr && (reg_req_i.addr == DIOEC_OFS_CTRL);
   assign rd_only = reg_req_i.rd && !reg_req_i.wr;
   // counts how long the pins stood still
   always_ff @(posedge clk_i) begin
      prev_r <= gpio_in_i;
      if (!nrst_i || gpio_in_i != prev_r)
         same_r <= 2'h0;
      else if (same_r != 2'h3)
         same_r <= same_r + 2'h1;
   end
   property p_reset_state;
      $rose(nrst_i) |-> gpio_oe_o == 72'h0 && status_led_o && !irq_o;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs not in reset state");
   property p_led;
      wr_ctrl |=> status_led_o == !$past(reg_req_i.wdata[17]);
   endproperty
   a_led: assert property (p_led)
      else $error("led does not follow latch mode");
   property p_gie_block;
      wr_ctrl && !reg_req_i.wdata[16] |=> !irq_o [*2];
   endproperty
   a_gie_block: assert property (p_gie_block)
      else $error("irq with global enable clear");
   property p_dir;
      wr_ctrl && !reg_req_i.wdata[17]
         |=> gpio_oe_o == grp($past(reg_req_i.wdata[9:0]));
   endproperty
   a_dir: assert property (p_dir)
      else $error("drive enables do not match direction");
   property p_out;
      reg_req_i.wr && reg_req_i.addr == DIOEC_OFS_PORT0
         |=> gpio_out_o[31:0] == $past(reg_req_i.wdata);
   endproperty
   a_out: assert property (p_out)
      else $error("output register not loaded");
   property p_gate;
      output_gate_strobe_n_i [*4] ##0 !status_led_o
         |-> gpio_oe_o[71:64] == 8'h00;
   endproperty
   a_gate: assert property (p_gate)
      else $error("latch channels driven without gate");
   property p_irq_stat;
      rd_only && reg_req_i.addr == DIOEC_OFS_CTRL
         |=> reg_rsp_o.rvalid && reg_rsp_o.rdata[31] == $past(irq_o);
   endproperty
   a_irq_stat: assert property (p_irq_stat)
      else $error("global request bit differs from irq");
   property p_port_rd;
      rd_only && reg_req_i.addr == DIOEC_OFS_PORT0 && same_r == 2'h3
         |=> reg_rsp_o.rdata == (($past(gpio_out_o[31:0])
            & $past(gpio_oe_o[31:0]))
            | ($past(gpio_in_i[31:0]) & ~$past(gpio_oe_o[31:0])));
   endproperty
   a_port_rd: assert property (p_port_rd)
      else $error("port read mixes pins and outputs wrongly");
endmodule
bind dioec_top dioec_checker #(.NUM_CH(NUM_CH), .NUM_EDGE(NUM_EDGE))
   dioec_checker_i (.clk_i(clk_i), .nrst_i(nrst_i),
   .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o),
   .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o),
   .gpio_oe_o(gpio_oe_o), .latch_strobe_i(latch_strobe_i),
   .output_gate_strobe_n_i(output_gate_strobe_n_i),
   .status_led_o(status_led_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/dioec_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dioec_pins_model (
   input  wire logic        clk_i,
   input  wire logic [71:0] out_i,
   input  wire logic [71:0] oe_i,
   input  wire logic [71:0] ext_i,
   input  wire logic        gate_i,
   input  wire logic        latch_i,
   output logic      [71:0] pin_o,
   output var logic         latch_strobe_o = 1'b1,
   output var logic         gate_n_o = 1'b1
);
   // device wins where it drives, far side elsewhere
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
   // strobes move just after a clock edge
   always @(posedge clk_i) begin
      latch_strobe_o <= !latch_i;
      gate_n_o <= !gate_i;
   end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dioec_pkg::*;
;
   logic          clk_i = 1'b0;
   logic          nrst_i = 1'b0;
   dioec_req_type req = '0;
   dioec_rsp_type rsp;
   logic [71:0]   pin, gout, goe, g, p;
   logic [71:0]   ext = '0;
   logic          lstb, gstb_n, led, irq;
   logic          gate = 1'b0;
   logic          latch = 1'b0;
   logic [63:0]   q[$];
   logic [63:0]   e;
   logic [31:0]   o0, o1, o2;
   logic [9:0]    d;
   int            n_errors = 0;
   int            check_count = 0;
   int            cycles = 0;
   int            seed = 32'hf288;

   dioec_top dioec_top_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .reg_req_i(req), .reg_rsp_o(rsp), .gpio_in_i(pin),
      .gpio_out_o(gout), .gpio_oe_o(goe), .latch_strobe_i(lstb),
      .output_gate_strobe_n_i(gstb_n), .status_led_o(led), .irq_o(irq));
   dioec_pins_model dioec_pins_model_i (.clk_i(clk_i), .out_i(gout),
      .oe_i(goe), .ext_i(ext), .gate_i(gate), .latch_i(latch),
      .pin_o(pin), .latch_strobe_o(lstb), .gate_n_o(gstb_n));

   // ----------
   // helpers
   // ----------
   always #25 clk_i = ~clk_i;
   function automatic logic [71:0] grp(input logic [9:0] dv);
      for (int i = 0; i < 72; i++)
         grp[i] = (i < 64) ? dv[i/8] : dv[8+(i-64)/4];
   endfunction
   task automatic end_of_test();
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      q.push_back({m, x & m});
      @(posedge clk_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_i);
      req.rd <= 1'b0;
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // watchdog on the run length
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
   // read answers against oldest note
   always @(posedge clk_i) begin
      if (rsp.rvalid === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         check(rsp.rdata & e[63:32], e[31:0]);
      end
   end

   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      look(1);
      check({30'h0, led, irq}, 32'h2);
      rd(DIOEC_OFS_CTRL, 32'h0003_03ff, 32'h0);
      rd(DIOEC_OFS_IEN0, '1, 32'h0);
      rd(DIOEC_OFS_IEN1, '1, 32'h0);
      // directions with random outputs and pins
      @(posedge clk_i);
      ext <= {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      o0 = $random(seed);
      o1 = $random(seed);
      o2 = $random(seed);
      wr(DIOEC_OFS_PORT0, o0);
      wr(DIOEC_OFS_PORT1, o1);
      wr(DIOEC_OFS_PORT2, o2);
      for (int i = 0; i < 11; i++) begin
         d = (i < 10) ? 10'(1 << i) : 10'h3ff;
         wr(DIOEC_OFS_CTRL, {22'h0, d});
         look(4);
         g = grp(d);
         p = ({o2[7:0], o1, o0} & g) | (ext & ~g);
         check(pin[31:0], p[31:0]);
         check(pin[63:32], p[63:32]);
         check({24'h0, pin[71:64]}, {24'h0, p[71:64]});
         rd(DIOEC_OFS_PORT0, '1, p[31:0]);
         rd(DIOEC_OFS_PORT1, '1, p[63:32]);
         rd(DIOEC_OFS_PORT2, 32'hff, {24'h0, p[71:64]});
      end
      // read-only places ignore writes
      wr(DIOEC_OFS_CTRL, 32'hfffc_7c00);
      wr(DIOEC_OFS_FLAG0, '1);
      wr(DIOEC_OFS_RO0C, '1);
      wr(8'h38, '1);
      rd(DIOEC_OFS_CTRL, '1, 32'h0);
      rd(DIOEC_OFS_FLAG0, '1, 32'h0);
      rd(8'h38, '1, 32'h0);
      // edge capture and interrupts
      @(posedge clk_i);
      ext <= 72'h00_0000_0002_0000_0001;
      wr(DIOEC_OFS_EDGE0, 32'h0);
      wr(DIOEC_OFS_EDGE1, 32'h2);
      wr(DIOEC_OFS_CTRL, 32'h0001_8000);
      wr(DIOEC_OFS_ARM0, 32'h1);
      wr(DIOEC_OFS_ARM1, 32'h2);
      wr(DIOEC_OFS_IEN0, 32'h1);
      rd(DIOEC_OFS_ARM0, '1, 32'h1);
      rd(DIOEC_OFS_ARM1, '1, 32'h2);
      @(posedge clk_i);
      ext <= 72'h0;
      look(5);
      check({31'h0, irq}, 32'h0);
      @(posedge clk_i);
      ext <= 72'h1;
      look(5);
      check({31'h0, irq}, 32'h1);
      rd(DIOEC_OFS_FLAG0, '1, 32'h1);
      rd(DIOEC_OFS_FLAG1, '1, 32'h0);
      rd(DIOEC_OFS_CTRL, '1, 32'h82a1_8000);
      wr(DIOEC_OFS_IEN1, 32'h2);
      rd(DIOEC_OFS_FLAG1, '1, 32'h2);
      wr(DIOEC_OFS_CTRL, 32'h0000_8000);
      look(1);
      check({31'h0, irq}, 32'h0);
      wr(DIOEC_OFS_CTRL, 32'h0001_0000);
      wr(DIOEC_OFS_ARM0, 32'h1);
      rd(DIOEC_OFS_FLAG0, '1, 32'h0);
      look(1);
      check({31'h0, irq}, 32'h1);
      wr(DIOEC_OFS_ARM1, 32'h2);
      look(1);
      check({31'h0, irq}, 32'h0);
      // latch and output gate mode
      wr(DIOEC_OFS_PORT2, 32'h5);
      wr(DIOEC_OFS_CTRL, 32'h0002_0100);
      look(4);
      check({31'h0, led}, 32'h0);
      check({24'h0, goe[71:64]}, 32'h0);
      @(posedge clk_i);
      gate <= 1'b1;
      ext[71:68] <= 4'ha;
      look(4);
      check({24'h0, goe[71:64]}, 32'h0f);
      @(posedge clk_i);
      latch <= 1'b1;
      look(4);
      @(posedge clk_i);
      ext[71:68] <= 4'h3;
      look(4);
      @(posedge clk_i);
      latch <= 1'b0;
      look(4);
      @(posedge clk_i);
      ext[71:68] <= 4'hc;
      gate <= 1'b0;
      look(4);
      rd(DIOEC_OFS_PORT2, 32'hff, 32'ha5);
      wr(DIOEC_OFS_CTRL, 32'h0000_0100);
      look(1);
      check({31'h0, led}, 32'h1);
      rd(DIOEC_OFS_PORT2, 32'hff, 32'hc5);
      look(3);
      end_of_test();
   end
endmodule
`default_nettype wire
